/* hdl/unit_clock_gating.sv */
// Register-programmed clock enables and access faults for the second unit group
`timescale 1ns/100ps
// How it works
// - Set gate bit clocks and enables unit
// - Clear bit stops clock, access faults
// - All gate bits reset to zero
// - Separate run, sleep, deep-sleep gate registers
// - Sleep registers act only with auto gating
// - Bits 18..16 gate counters 2..0
// - Bit 4 gates sync serial 0
// - Bit 0 gates async serial 0
// - Bits 26..24 gate comparators 2..0
// - Reserved bits read-only, read zero
// - Run register at 0x104, resets zero
// - Sleep register at 0x114, resets zero
// - Deep-sleep register at 0x124, same layout
module unit_clock_gating
    import clock_gating_pkg::*;
#(
    parameter int NUM_UNITS = UNIT_COUNT,
    parameter int DATA_W    = REG_W
) (
    input  wire logic            I_SYS_CLK,
    input  wire logic            I_RST,
    input  wire reg_req_type     I_REG_REQ,
    output logic [DATA_W-1:0]    O_REG_RDATA,
    input  wire power_state_type I_POWER_STATE,
    input  wire logic [NUM_UNITS-1:0] I_UNIT_ACCESS,
    output logic [NUM_UNITS-1:0] O_UNIT_CLK_EN,
    output logic                 O_BUS_FAULT,
    output logic                 O_IRQ
);

    localparam int IDX_W = $clog2(UNIT_COUNT);

    // The bit table and the read mux are built for exactly this shape
    generate
        if (NUM_UNITS != UNIT_COUNT || DATA_W != REG_W) begin : g_bad_shape
            $error("unit_clock_gating: unsupported NUM_UNITS or DATA_W");
        end
    endgenerate

    // Register state
    logic [DATA_W-1:0]    run_en_q;
    logic [DATA_W-1:0]    sleep_en_q;
    logic [DATA_W-1:0]    deep_en_q;
    logic                 auto_gate_q;
    logic [NUM_UNITS-1:0] int_status_q;
    logic [NUM_UNITS-1:0] int_status_d;
    logic [NUM_UNITS-1:0] int_mask_q;
    logic [NUM_UNITS-1:0] clk_en_q;
    logic                 fault_q;
    logic                 irq_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [IDX_W-1:0]     fault_idx_q;
    logic [IDX_W-1:0]     fault_idx_d;
    logic                 fault_seen_q;

    // Address decode
    wire logic do_wr     = I_REG_REQ.wr;
    wire logic do_rd     = I_REG_REQ.rd;
    wire logic hit_cfg   = I_REG_REQ.addr == RUN_CFG_OFS;
    wire logic hit_run   = I_REG_REQ.addr == RUN_EN_OFS;
    wire logic hit_sleep = I_REG_REQ.addr == SLEEP_EN_OFS;
    wire logic hit_deep  = I_REG_REQ.addr == DEEP_EN_OFS;
    wire logic hit_stat  = I_REG_REQ.addr == INT_STATUS_OFS;
    wire logic hit_mask  = I_REG_REQ.addr == INT_MASK_OFS;
    wire logic hit_info  = I_REG_REQ.addr == FAULT_INFO_OFS;
    wire logic hit_act   = I_REG_REQ.addr == ACTIVE_EN_OFS;

    // Only documented gate bits are storable; the rest stay zero
    wire logic [DATA_W-1:0] gate_wdata = I_REG_REQ.wdata & GATE_WRITE_MASK;

    // Register selection by power state
    wire logic use_sleep = auto_gate_q && (I_POWER_STATE == PWR_SLEEP);
    wire logic use_deep  = auto_gate_q && (I_POWER_STATE == PWR_DEEP);
    wire logic [DATA_W-1:0] sel_word = use_sleep ? sleep_en_q :
                                       use_deep  ? deep_en_q  : run_en_q;

    // Per-unit views of the gate words
    logic [NUM_UNITS-1:0] run_units;
    logic [NUM_UNITS-1:0] sleep_units;
    logic [NUM_UNITS-1:0] deep_units;
    logic [NUM_UNITS-1:0] unit_sel;
    logic [NUM_UNITS-1:0] fault_evt;

    generate
        for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
            assign run_units[u]   = run_en_q[UNIT_BIT[u]];
            assign sleep_units[u] = sleep_en_q[UNIT_BIT[u]];
            assign deep_units[u]  = deep_en_q[UNIT_BIT[u]];
            assign unit_sel[u]    = sel_word[UNIT_BIT[u]];
            // Fault against the enable the unit actually sees now
            assign fault_evt[u]   = I_UNIT_ACCESS[u] & ~clk_en_q[u];
        end
    endgenerate

    // Interrupt status, write one to clear; a new fault beats the clear
    wire logic [NUM_UNITS-1:0] stat_clr =
        (do_wr && hit_stat) ? I_REG_REQ.wdata[NUM_UNITS-1:0] : '0;
    assign int_status_d = (int_status_q & ~stat_clr) | fault_evt;

    wire logic [NUM_UNITS-1:0] mask_d =
        (do_wr && hit_mask) ? I_REG_REQ.wdata[NUM_UNITS-1:0] : int_mask_q;

    // Lowest faulting unit is reported when several fault together
    always_comb begin
        fault_idx_d = fault_idx_q;
        for (int i = NUM_UNITS - 1; i >= 0; i--) begin
            if (fault_evt[i]) begin
                fault_idx_d = IDX_W'(i);
            end
        end
    end

    // Read mux
    wire logic [DATA_W-1:0] cfg_word  = {{(DATA_W-1){1'b0}}, auto_gate_q};
    wire logic [DATA_W-1:0] stat_word = {{(DATA_W-NUM_UNITS){1'b0}}, int_status_q};
    wire logic [DATA_W-1:0] mask_word = {{(DATA_W-NUM_UNITS){1'b0}}, int_mask_q};
    wire logic [DATA_W-1:0] act_word  = {{(DATA_W-NUM_UNITS){1'b0}}, clk_en_q};
    wire logic [DATA_W-1:0] info_word =
        {fault_seen_q, {(DATA_W-1-IDX_W){1'b0}}, fault_idx_q};
    wire logic [DATA_W-1:0] rd_mux =
        hit_cfg   ? cfg_word   :
        hit_run   ? run_en_q   :
        hit_sleep ? sleep_en_q :
        hit_deep  ? deep_en_q  :
        hit_stat  ? stat_word  :
        hit_mask  ? mask_word  :
        hit_info  ? info_word  :
        hit_act   ? act_word   : READ_IDLE;

    // Gate registers
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            run_en_q   <= GATE_RESET;
            sleep_en_q <= GATE_RESET;
            deep_en_q  <= GATE_RESET;
        end else if (do_wr) begin
            if (hit_run) begin
                run_en_q <= gate_wdata;
            end
            if (hit_sleep) begin
                sleep_en_q <= gate_wdata;
            end
            if (hit_deep) begin
                deep_en_q <= gate_wdata;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            auto_gate_q <= 1'b0;
        end else if (do_wr && hit_cfg) begin
            auto_gate_q <= I_REG_REQ.wdata[AUTO_GATING_BIT];
        end
    end

    // Enables change only just after a rising edge, so the downstream
    // latch-based gate cells never see a change while the clock is low
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            clk_en_q <= '0;
        end else begin
            clk_en_q <= unit_sel;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= |fault_evt;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            int_status_q <= '0;
            int_mask_q   <= '0;
            irq_q        <= 1'b0;
        end else begin
            int_status_q <= int_status_d;
            int_mask_q   <= mask_d;
            irq_q        <= |(int_status_d & mask_d);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            fault_idx_q  <= '0;
            fault_seen_q <= 1'b0;
        end else begin
            fault_idx_q  <= fault_idx_d;
            fault_seen_q <= fault_seen_q | (|fault_evt);
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rdata_q <= READ_IDLE;
        end else begin
            rdata_q <= do_rd ? rd_mux : READ_IDLE;
        end
    end

    assign O_UNIT_CLK_EN = clk_en_q;
    assign O_BUS_FAULT   = fault_q;
    assign O_IRQ         = irq_q;
    assign O_REG_RDATA   = rdata_q;

    // Checks
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_run_write;
        do_wr && !do_rd && hit_run;
    endsequence

    sequence s_run_read;
        do_rd && !do_wr && hit_run;
    endsequence

    sequence s_sleep_write;
        do_wr && !do_rd && hit_sleep;
    endsequence

    sequence s_sleep_read;
        do_rd && !do_wr && hit_sleep;
    endsequence

    sequence s_gate_read;
        do_rd && (hit_run || hit_sleep || hit_deep);
    endsequence

    sequence s_deep_write;
        do_wr && !do_rd && hit_deep;
    endsequence

    sequence s_deep_read;
        do_rd && !do_wr && hit_deep;
    endsequence

    sequence s_stat_clear0;
        do_wr && hit_stat && I_REG_REQ.wdata[0] && !fault_evt[0];
    endsequence

    property p_run_applies;
        (!auto_gate_q || I_POWER_STATE == PWR_RUN)
            |=> (O_UNIT_CLK_EN == $past(run_units));
    endproperty
    a_run_applies: assert property (p_run_applies)
        else $error("Run gate word not applied to unit enables");

    property p_sleep_applies;
        (auto_gate_q && I_POWER_STATE == PWR_SLEEP)
            |=> (O_UNIT_CLK_EN == $past(sleep_units));
    endproperty
    a_sleep_applies: assert property (p_sleep_applies)
        else $error("Sleep gate word not applied in sleep");

    property p_deep_applies;
        (auto_gate_q && I_POWER_STATE == PWR_DEEP)
            |=> (O_UNIT_CLK_EN == $past(deep_units));
    endproperty
    a_deep_applies: assert property (p_deep_applies)
        else $error("Deep-sleep gate word not applied in deep sleep");

    property p_fault_on_gated;
        (|(I_UNIT_ACCESS & ~O_UNIT_CLK_EN)) |=> O_BUS_FAULT;
    endproperty
    a_fault_on_gated: assert property (p_fault_on_gated)
        else $error("Access to an unclocked unit did not fault");

    property p_no_false_fault;
        !(|(I_UNIT_ACCESS & ~O_UNIT_CLK_EN)) |=> !O_BUS_FAULT;
    endproperty
    a_no_false_fault: assert property (p_no_false_fault)
        else $error("Fault raised for a clocked unit");

    property p_fault_sticks;
        (I_UNIT_ACCESS[0] && !O_UNIT_CLK_EN[0]) |=> int_status_q[0] ##1 (int_status_q[0]
            || (do_wr && hit_stat));
    endproperty
    a_fault_sticks: assert property (p_fault_sticks)
        else $error("Fault status bit lost or cleared by itself");

    property p_reset_zero;
        $fell(I_RST) |-> (run_en_q == GATE_RESET && sleep_en_q == GATE_RESET
            && deep_en_q == GATE_RESET && O_UNIT_CLK_EN == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Gate state not zero after reset");

    property p_run_readback;
        s_run_write ##1 s_run_read
            |=> (O_REG_RDATA == ($past(I_REG_REQ.wdata, 2) & GATE_WRITE_MASK));
    endproperty
    a_run_readback: assert property (p_run_readback)
        else $error("Run gate register read back wrong");

    property p_sleep_readback;
        s_sleep_write ##1 s_sleep_read
            |=> (O_REG_RDATA == ($past(I_REG_REQ.wdata, 2) & GATE_WRITE_MASK));
    endproperty
    a_sleep_readback: assert property (p_sleep_readback)
        else $error("Sleep gate register read back wrong");

    property p_reserved_zero;
        s_gate_read |=> ((O_REG_RDATA & ~GATE_WRITE_MASK) == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved gate bits read non-zero");

    property p_enable_steady;
        $stable(sel_word) ##1 $stable(sel_word) |=> $stable(O_UNIT_CLK_EN);
    endproperty
    a_enable_steady: assert property (p_enable_steady)
        else $error("Unit enable moved without a gate word change");

    property p_irq_level;
        ##1 (O_IRQ == |(int_status_q & int_mask_q));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output disagrees with masked status");

    property p_deep_readback;
        s_deep_write ##1 s_deep_read
            |=> (O_REG_RDATA == ($past(I_REG_REQ.wdata, 2) & GATE_WRITE_MASK));
    endproperty
    a_deep_readback: assert property (p_deep_readback)
        else $error("Deep-sleep gate register read back wrong");

    // Read data must not linger, the bus has no valid flag
    property p_rdata_idle;
        !do_rd |=> (O_REG_RDATA == READ_IDLE);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("Read data not idle outside a read answer");

    property p_status_clear;
        s_stat_clear0 |=> !int_status_q[0];
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("Status bit survived its write-one clear");

endmodule

/* inc/clock_gating_pkg.sv */
// Constants, types and register map of the peripheral clock gating block
package clock_gating_pkg;

    localparam int REG_W      = 32;
    localparam int ADDR_W     = 12;
    localparam int UNIT_COUNT = 8;

    // Block base in the system map; the port carries only the offset
    localparam logic [31:0] SYS_CTRL_BASE = 32'h400f_e000;

    localparam logic [ADDR_W-1:0] RUN_CFG_OFS    = 12'h060;
    localparam logic [ADDR_W-1:0] RUN_EN_OFS     = 12'h104;
    localparam logic [ADDR_W-1:0] SLEEP_EN_OFS   = 12'h114;
    localparam logic [ADDR_W-1:0] DEEP_EN_OFS    = 12'h124;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 12'h130;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS   = 12'h134;
    localparam logic [ADDR_W-1:0] FAULT_INFO_OFS = 12'h138;
    localparam logic [ADDR_W-1:0] ACTIVE_EN_OFS  = 12'h13c;

    // Unit order: async serial 0, sync serial 0, counters 0..2, comparators a..c
    localparam int UNIT_BIT [UNIT_COUNT] = '{0, 4, 16, 17, 18, 24, 25, 26};

    localparam logic [REG_W-1:0] GATE_WRITE_MASK = 32'h0707_0011;
    localparam logic [REG_W-1:0] GATE_RESET      = 32'h0000_0000;
    localparam logic [REG_W-1:0] READ_IDLE       = 32'h0000_0000;

    localparam int AUTO_GATING_BIT  = 0;
    localparam int FAULT_VALID_BIT  = 31;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_DEEP
    } power_state_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

endpackage

/* tb/peripheral_clock_gating_set1_tb_top.sv */
// Self-checking testbench of the unit clock gating block
`timescale 1ns/100ps
module peripheral_clock_gating_set1_tb_top;
    import clock_gating_pkg::*;

    logic            sys_clk = 1'b0;
    logic            rst     = 1'b1;
    reg_req_type     req     = '0;
    power_state_type pstate  = PWR_RUN;
    logic [7:0]      touch   = '0;
    logic [7:0]      access;
    logic [7:0]      clk_en;
    logic [7:0]      live;
    logic [31:0]     rdata;
    logic [31:0]     rd_val;
    logic            fault;
    logic            irq;
    int              err_count  = 0;
    int              num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    unit_clock_gating dut (
        .I_SYS_CLK    (sys_clk),
        .I_RST        (rst),
        .I_REG_REQ    (req),
        .O_REG_RDATA  (rdata),
        .I_POWER_STATE(pstate),
        .I_UNIT_ACCESS(access),
        .O_UNIT_CLK_EN(clk_en),
        .O_BUS_FAULT  (fault),
        .O_IRQ        (irq)
    );

    peripheral_units_model units (
        .i_clk   (sys_clk),
        .i_rst   (rst),
        .i_clk_en(clk_en),
        .i_touch (touch),
        .o_access(access),
        .o_live  (live)
    );

    function automatic logic [7:0] en_of(input logic [31:0] v);
        logic [7:0] e;
        for (int u = 0; u < UNIT_COUNT; u++) e[u] = v[UNIT_BIT[u]];
        return e;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        rd_val = rdata;
        chk($sformatf("read %h", a), exp, rdata);
        @(negedge sys_clk);
        chk("read idle", READ_IDLE, rdata);
    endtask

    // Back-to-back write and read of one register, no idle cycle between
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("readback %h", a), exp, rdata);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    logic [11:0] regs [6] = '{RUN_EN_OFS, SLEEP_EN_OFS, DEEP_EN_OFS, INT_STATUS_OFS,
                              INT_MASK_OFS, ACTIVE_EN_OFS};
    logic [31:0] gates [3] = '{32'h0707_0011, 32'h0101_0001, 32'h0202_0010};

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        chk("clk_en", 32'h0, clk_en);
        $display("test reset done");

        // All ones to run proves the writable mask; distinct values prove separation
        wr(RUN_EN_OFS, 32'hffff_ffff);
        wr(SLEEP_EN_OFS, gates[1]);
        wr(DEEP_EN_OFS, gates[2]);
        wr(12'h200, 32'hffff_ffff);
        rd(RUN_EN_OFS, gates[0]);
        rd(SLEEP_EN_OFS, gates[1]);
        rd(DEEP_EN_OFS, gates[2]);
        rd(12'h200, 32'h0);
        wr_rd(RUN_EN_OFS, 32'hffff_ffff, gates[0]);
        wr_rd(SLEEP_EN_OFS, gates[1], gates[1]);
        wr_rd(DEEP_EN_OFS, 32'hffff_ffff, gates[0]);
        wr_rd(DEEP_EN_OFS, gates[2], gates[2]);
        $display("test layout done");

        for (int ag = 0; ag < 2; ag++) begin
            wr(RUN_CFG_OFS, 32'(ag));
            rd(RUN_CFG_OFS, 32'(ag));
            for (int s = 0; s < 3; s++) begin
                @(posedge sys_clk);
                pstate <= power_state_type'(s);
                settle(3);
                chk("clk_en", en_of(gates[ag * s]), clk_en);
                chk("live", en_of(gates[ag * s]), live);
                rd(ACTIVE_EN_OFS, 32'(en_of(gates[ag * s])));
            end
        end
        wr(RUN_CFG_OFS, 32'h0);
        @(posedge sys_clk);
        pstate <= PWR_RUN;
        $display("test power states done");

        for (int u = 0; u < UNIT_COUNT; u++) begin
            wr(RUN_EN_OFS, gates[0] & ~(32'h1 << UNIT_BIT[u]));
            wr(INT_MASK_OFS, 32'h1 << u);
            settle(3);
            chk("live", 32'(8'hff & ~(8'h1 << u)), live);
            @(posedge sys_clk);
            touch <= 8'hff;
            @(posedge sys_clk);
            touch <= 8'h00;
            @(negedge sys_clk);
            chk("fault", 32'h1, fault);
            settle(1);
            chk("fault end", 32'h0, fault);
            chk("irq", 32'h1, irq);
            rd(INT_STATUS_OFS, 32'h1 << u);
            rd(FAULT_INFO_OFS, (32'h1 << FAULT_VALID_BIT) | 32'(u));
            wr(INT_STATUS_OFS, 32'h1 << u);
            settle(2);
            chk("irq clear", 32'h0, irq);
        end
        // Two units gated at once; mask holds only the last unit, so no interrupt
        wr(RUN_EN_OFS, gates[0] & ~((32'h1 << UNIT_BIT[3]) | (32'h1 << UNIT_BIT[6])));
        settle(3);
        @(posedge sys_clk);
        touch <= 8'hff;
        @(posedge sys_clk);
        touch <= 8'h00;
        settle(1);
        chk("irq masked", 32'h0, irq);
        rd(INT_STATUS_OFS, 32'h48);
        rd(FAULT_INFO_OFS, (32'h1 << FAULT_VALID_BIT) | 32'h3);
        rd(INT_MASK_OFS, 32'h80);
        wr(INT_STATUS_OFS, 32'h48);
        rd(INT_STATUS_OFS, 32'h0);
        wr(RUN_EN_OFS, gates[0]);
        settle(3);
        @(posedge sys_clk);
        touch <= 8'hff;
        @(posedge sys_clk);
        touch <= 8'h00;
        @(negedge sys_clk);
        chk("no fault", 32'h0, fault);
        $display("test faults done");

        // Software keeps reserved bits when it turns one unit off
        rd(RUN_EN_OFS, gates[0]);
        wr(RUN_EN_OFS, rd_val & ~32'h1);
        rd(RUN_EN_OFS, 32'h0707_0010);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(RUN_EN_OFS, 32'h0);
        rd(FAULT_INFO_OFS, 32'h0);
        chk("clk_en after reset", 32'h0, clk_en);
        $display("test rmw and reset done");
        stop_test();
    end

    // Watchdog in case the sequence hangs
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        stop_test();
    end
endmodule

/* tb/peripheral_units_model.sv */
// Behavioural model of the gated peripheral units behind the clock enables
`timescale 1ns/100ps
module peripheral_units_model
    import clock_gating_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic [UNIT_COUNT-1:0] i_clk_en,
    input  wire logic [UNIT_COUNT-1:0] i_touch,
    output logic      [UNIT_COUNT-1:0] o_access,
    output logic      [UNIT_COUNT-1:0] o_live
);
    // Access is not held back for unclocked units, so faults can be provoked
    assign o_access = i_touch;

    // A unit counts as alive when it saw a gated clock edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_live <= '0;
        end else begin
            o_live <= i_clk_en;
        end
    end
endmodule
